// ===== inc/pid_map.svh
// Bus widths, field positions, reset values and codes of the identity register block
`ifndef PID_MAP_SVH
`define PID_MAP_SVH

// ****************************************************************
// Bus widths
// ****************************************************************
`define PID_LINE_W         16
`define PID_ADDR_UPPER_W   7

// ****************************************************************
// Register select codes
// ****************************************************************
`define PID_SEL_LSB        2
`define PID_SEL_MSB        3
`define PID_SEL_IDENTITY   2'h1
`define PID_SW_SEL_IDENTITY 16'h0002

// ****************************************************************
// Identity word field positions
// ****************************************************************
`define PID_ROW_POS        15
`define PID_VER_LSB        11
`define PID_VER_MSB        14
`define PID_DEN_LSB        8
`define PID_DEN_MSB        10
`define PID_GEN_LSB        5
`define PID_GEN_MSB        7
`define PID_VEN_LSB        0
`define PID_VEN_MSB        4

// ****************************************************************
// Identity word field values
// ****************************************************************
`define PID_ROW_256        1'h1
`define PID_VER_FIRST      4'h0
`define PID_VER_SECOND     4'h1
`define PID_DEN_128MB      3'h3

// ****************************************************************
// Reset values
// ****************************************************************
`define PID_LINE_RESET     16'h0000
`define PID_ADDR_RESET     7'h00

`endif

// ===== inc/pid_pkg.sv
// Types shared by the identity register block
`include "pid_map.svh"

package pid_pkg;

    // ****************************************************************
    // Memory interface pins as seen by the device
    // ****************************************************************
    typedef struct packed {
        logic                          ceN;        // Chip enable, active low
        logic                          advN;       // Address valid, active low
        logic                          oeN;        // Output enable, active low
        logic                          weN;        // Write enable, active low
        logic                          configRegisterEnablePin; // Config enable, high
        logic [`PID_ADDR_UPPER_W-1:0]  addrUpper;               // Upper address, bit 0 is A16
        logic [`PID_LINE_W-1:0]        muxedAddrDataLines;      // Muxed address/data in
    } pid_pins_t;

    // ****************************************************************
    // Software access sequence progress
    // ****************************************************************
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_READ1,
        SEQ_READ2,
        SEQ_ARMED
    } pid_seq_t;

    // ****************************************************************
    // Whole state of the block
    // ****************************************************************
    typedef struct packed {
        pid_pins_t               s1;        // Synchroniser stage one
        pid_pins_t               s2;        // Synchroniser stage two
        pid_pins_t               s3;        // Synchroniser stage three
        pid_pins_t               q;         // Qualified pin levels
        logic                    cfgOn;     // Latched config enable
        logic                    cfgHit;    // Latched select code is identity
        logic                    isMax;     // Latched address is all ones
        logic                    wrSeen;    // Current access is a write
        logic [`PID_LINE_W-1:0]  wrData;    // Last write data of the access
        pid_seq_t                seq;       // Software sequence step
        logic [`PID_LINE_W-1:0]  lineOut;   // Read data driven out
        logic                    lineOe;    // Read data enable
    } pid_state_t;

endpackage

// ===== rtl/pid_device_identity_register.sv
// Read-only device identity register behind the muxed memory pins
`timescale 1ns/100ps
`default_nettype none
`include "pid_map.svh"

module pid_device_identity_register #(
    parameter logic [3:0] VERSION    = `PID_VER_FIRST,   // Device version field
    parameter logic [2:0] GENERATION = 3'h5,             // Arbitrary value
    parameter logic [4:0] VENDOR     = 5'h0b             // Arbitrary value
) (
    input  wire logic                     clock,      // 100 MHz clock
    input  wire logic                     rst_n,      // Async reset, active low
    input  wire pid_pkg::pid_pins_t       pins,       // Memory pins, asynchronous
    output var  logic [`PID_LINE_W-1:0]   lineOut,    // Muxed lines, read data
    output var  logic                     lineOe,     // Muxed lines driven, high
    output var  logic                     seqArmed    // Software sequence armed
);
    import pid_pkg::*;

    // ****************************************************************
    // Parameter checks
    // ****************************************************************
    if (VERSION != `PID_VER_FIRST && VERSION != `PID_VER_SECOND) begin : gVerChk
        $error("VERSION must be first or second");
    end

    // ****************************************************************
    // Constants
    // ****************************************************************
    // Idle level of the pins: chip deselected, strobes high
    localparam pid_pins_t PINS_IDLE = '{
        ceN:       1'b1,
        advN:      1'b1,
        oeN:       1'b1,
        weN:       1'b1,
        configRegisterEnablePin: 1'b0,
        addrUpper:               `PID_ADDR_RESET,
        muxedAddrDataLines:      `PID_LINE_RESET
    };

    localparam pid_state_t ST_RESET = '{
        s1:     PINS_IDLE,
        s2:     PINS_IDLE,
        s3:     PINS_IDLE,
        q:      PINS_IDLE,
        cfgOn:   1'b0,
        cfgHit:  1'b0,
        isMax:   1'b0,
        wrSeen:  1'b0,
        wrData:  `PID_LINE_RESET,
        seq:     SEQ_IDLE,
        lineOut: `PID_LINE_RESET,
        lineOe:  1'b0
    };

    localparam int PW = $bits(pid_pins_t);

    // ****************************************************************
    // Identity word
    // ****************************************************************
    logic [`PID_LINE_W-1:0] idWord;

    // Fixed content; nothing on the bus ever reaches these bits
    always_comb begin
        idWord = `PID_LINE_RESET;
        idWord[`PID_ROW_POS]               = `PID_ROW_256;
        idWord[`PID_VER_MSB:`PID_VER_LSB]  = VERSION;
        idWord[`PID_DEN_MSB:`PID_DEN_LSB]  = `PID_DEN_128MB;
        idWord[`PID_GEN_MSB:`PID_GEN_LSB]  = GENERATION;
        idWord[`PID_VEN_MSB:`PID_VEN_LSB]  = VENDOR;
    end

    // ****************************************************************
    // State update
    // ****************************************************************
    pid_state_t       st;
    pid_state_t       next_st;
    logic [PW-1:0]    s2Vec;
    logic [PW-1:0]    s3Vec;
    logic [PW-1:0]    qVec;
    logic [PW-1:0]    diffVec;
    pid_pins_t        nq;
    logic             accStart;
    logic             accEnd;
    logic             idSel;

    // Pin qualification: a bit moves only once stages two and three agree,
    // so a single glitch sampled by stage one never reaches the logic
    always_comb begin
        s2Vec   = st.s2;
        s3Vec   = st.s3;
        qVec    = st.q;
        diffVec = s2Vec ^ s3Vec;
        nq      = pid_pins_t'((s2Vec & ~diffVec) | (qVec & diffVec));
    end

    always_comb begin
        next_st    = st;
        next_st.s1 = pins;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.q  = nq;
        accStart   = st.q.ceN && !nq.ceN;
        accEnd     = !st.q.ceN && nq.ceN;

        // A new access forgets the previous write and selection
        if (accStart) begin
            next_st.wrSeen = 1'b0;
            next_st.cfgOn  = 1'b0;
            next_st.cfgHit = 1'b0;
            next_st.isMax  = 1'b0;
        end

        // Address phase: latch select and top-address flag while ADV is low
        if (!nq.ceN && !nq.advN) begin
            next_st.cfgOn  = nq.configRegisterEnablePin;
            next_st.cfgHit = nq.configRegisterEnablePin &&
                (nq.addrUpper[`PID_SEL_MSB:`PID_SEL_LSB] == `PID_SEL_IDENTITY);
            next_st.isMax  = (&nq.addrUpper) && (&nq.muxedAddrDataLines);
        end

        // Write phase: keep the data only for the sequence selector
        if (!nq.ceN && nq.advN && !nq.weN) begin
            next_st.wrSeen = 1'b1;
            next_st.wrData = nq.muxedAddrDataLines;
        end

        // Sequence advances when an access closes; config-pin accesses break it
        if (accEnd) begin
            if (st.cfgOn) begin
                next_st.seq = SEQ_IDLE;
            end else begin
                unique case (st.seq)
                    SEQ_IDLE: begin
                        next_st.seq = (st.isMax && !st.wrSeen) ? SEQ_READ1 : SEQ_IDLE;
                    end
                    SEQ_READ1: begin
                        next_st.seq = (st.isMax && !st.wrSeen) ? SEQ_READ2 : SEQ_IDLE;
                    end
                    SEQ_READ2: begin
                        // Third cycle carries the register selector
                        next_st.seq = (st.isMax && st.wrSeen &&
                            st.wrData == `PID_SW_SEL_IDENTITY) ? SEQ_ARMED : SEQ_IDLE;
                    end
                    SEQ_ARMED: begin
                        // Armed access has completed; writes to it were dropped
                        next_st.seq = SEQ_IDLE;
                    end
                endcase
            end
        end

        // Config pin takes priority over an armed sequence
        idSel = next_st.cfgOn ? next_st.cfgHit : (next_st.seq == SEQ_ARMED);

        // Read phase: drive only with OE low and WE high after the address phase
        next_st.lineOe  = !nq.ceN && nq.advN && !nq.oeN && nq.weN && idSel;
        next_st.lineOut = next_st.lineOe ? idWord : `PID_LINE_RESET;
    end

    // State register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // lineOut and lineOe come straight from the state register; seqArmed is decoded from st.seq
    assign lineOut  = st.lineOut;
    assign lineOe   = st.lineOe;
    assign seqArmed = (st.seq == SEQ_ARMED);

endmodule

`default_nettype wire

// ===== dv/pid_chk.sv
// Checker of the identity register pin behaviour
`timescale 1ns/100ps
`default_nettype none
`include "pid_map.svh"
module pid_chk #(
    parameter logic [3:0] VERSION    = `PID_VER_FIRST, // Version field
    parameter logic [2:0] GENERATION = 3'h5,           // Arbitrary value
    parameter logic [4:0] VENDOR     = 5'h0b           // Arbitrary value
) (
    input wire logic                  clock,    // Clock
    input wire logic                  rst_n,    // Reset, active low
    input wire pid_pkg::pid_pins_t    pins,     // Memory pins
    input wire logic [`PID_LINE_W-1:0] lineOut, // Read data
    input wire logic                  lineOe,   // Read data enable
    input wire logic                  seqArmed  // Sequence armed
);
    import pid_pkg::*;
    localparam logic [15:0] WORD = {`PID_ROW_256, VERSION, `PID_DEN_128MB, GENERATION, VENDOR};
    // ****
    // Checks, one clock domain
    // ****
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Word is constant, so a write leaking into it shows here
    chk_word_value: assert property (lineOe |-> lineOut == WORD)
        else $error("identity word wrong while driven");
    chk_idle_zero: assert property (!lineOe |-> lineOut == 16'h0000)
        else $error("read data not zero while undriven");
    chk_write_quiet: assert property ((!pins.weN)[*5] |-> !lineOe)
        else $error("lines driven during a write");
    chk_chip_off: assert property (pins.ceN[*5] |-> !lineOe)
        else $error("lines driven with chip disabled");
    chk_drive_cause: assert property ($rose(lineOe) |->
        !$past(pins.ceN, 4) && !$past(pins.oeN, 4) && $past(pins.weN, 4))
        else $error("drive began without a read phase");
    chk_armed_end: assert property ($rose(seqArmed) |-> $past(pins.ceN, 3))
        else $error("sequence armed before access ended");
    cover property ($rose(lineOe));
    cover property ($rose(seqArmed));
    cover property (!pins.weN && !pins.ceN && pins.configRegisterEnablePin);
endmodule
`default_nettype wire

// ===== dv/pid_ctrl_model.sv
// Memory controller model driving the muxed pins
`timescale 1ns/100ps
`default_nettype none
module pid_ctrl_model (
    input wire logic        clock,   // Clock
    input wire logic [15:0] lineOut, // Device read data
    input wire logic        lineOe,  // Device drives lines
    output var pid_pkg::pid_pins_t pins // Resolved pins
);
    import pid_pkg::*;
    pid_pins_t drv;
    initial drv = '{ceN: 1'b1, advN: 1'b1, oeN: 1'b1, weN: 1'b1, default: '0};
    // Shared lines carry the device's word when it drives them
    always_comb begin
        pins = drv;
        if (lineOe) pins.muxedAddrDataLines = lineOut;
    end
    // One access; a released bus shows the inverse so stale data never matches
    task automatic access(input logic c, input logic [6:0] au, input logic [15:0] a,
                          input logic wr, input logic [15:0] d,
                          output logic [15:0] rd, output logic oe);
        @(posedge clock);
        drv.ceN <= 1'b0;
        drv.advN <= 1'b0;
        drv.configRegisterEnablePin <= c;
        drv.addrUpper <= au;
        drv.muxedAddrDataLines <= a;
        repeat (5) @(posedge clock);
        drv.advN <= 1'b1;
        drv.muxedAddrDataLines <= wr ? d : ~a;
        drv.weN <= !wr;
        drv.oeN <= wr;
        repeat (8) @(posedge clock);
        rd = lineOut;
        oe = lineOe;
        drv.ceN <= 1'b1;
        drv.oeN <= 1'b1;
        drv.weN <= 1'b1;
        drv.configRegisterEnablePin <= 1'b0;
        drv.muxedAddrDataLines <= ~drv.muxedAddrDataLines;
        repeat (6) @(posedge clock);
    endtask
endmodule
`default_nettype wire

// ===== dv/pid_device_identity_register_tb.sv
// Self-checking bench of the identity register
`timescale 1ns/100ps
`default_nettype none
`include "pid_map.svh"
module pid_device_identity_register_tb;
    import pid_pkg::*;
    localparam logic [3:0] VER = `PID_VER_SECOND;
    localparam logic [2:0] GEN = 3'h6;  // Arbitrary value
    localparam logic [4:0] VEN = 5'h15; // Arbitrary value
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    pid_pins_t pins;
    logic [15:0] lineOut;
    logic lineOe, seqArmed, oe;
    logic [15:0] rd, r;
    int miscompares = 0;
    int n_compared = 0;
    int cyc = 0;
    pid_device_identity_register #(.VERSION(VER), .GENERATION(GEN), .VENDOR(VEN))
        pid_device_identity_register_inst (.clock(clock), .rst_n(rst_n), .pins(pins),
        .lineOut(lineOut), .lineOe(lineOe), .seqArmed(seqArmed));
    pid_ctrl_model ctrl (.clock(clock), .lineOut(lineOut), .lineOe(lineOe), .pins(pins));
    // ****
    // Helpers
    // ****
    function automatic logic [15:0] exp_word();
        return {`PID_ROW_256, VER, `PID_DEN_128MB, GEN, VEN};
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial forever #5 clock = ~clock;
    // Hang guard, well above the 14 accesses' worth of cycles
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            finish_test();
        end
    end
    // ****
    // Tests
    // ****
    initial begin
        void'($urandom(32'h7d262f25));
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        // Every select code with random neighbouring bits; only 01 answers
        for (int s = 0; s < 4; s++) begin
            r = 16'($urandom);
            ctrl.access(1'b1, {r[6:4], 2'(s), r[1:0]}, r, 1'b0, 16'h0, rd, oe);
            chk("config drive", {15'h0, s == 1}, {15'h0, oe});
            chk("config word", (s == 1) ? exp_word() : 16'h0, rd);
        end
        $display("test config select done");
        // Write to the register, then read it back unchanged
        r = 16'($urandom);
        ctrl.access(1'b1, 7'h04, r, 1'b1, ~exp_word(), rd, oe);
        chk("write drive", 16'h0, {15'h0, oe});
        ctrl.access(1'b1, 7'h04, r, 1'b0, 16'h0, rd, oe);
        chk("after write", exp_word(), rd);
        $display("test write done");
        // Software sequence, identity selector and another register's selector
        for (int k = 0; k < 2; k++) begin
            ctrl.access(1'b0, 7'h7f, 16'hffff, 1'b0, 16'h0, rd, oe);
            ctrl.access(1'b0, 7'h7f, 16'hffff, 1'b0, 16'h0, rd, oe);
            ctrl.access(1'b0, 7'h7f, 16'hffff, 1'b1, k ? 16'h0000 : 16'h0002, rd, oe);
            chk("armed", {15'h0, k == 0}, {15'h0, seqArmed});
            ctrl.access(1'b0, 7'($urandom), 16'($urandom), 1'b0, 16'h0, rd, oe);
            chk("sw word", k ? 16'h0 : exp_word(), rd);
            chk("disarmed", 16'h0, {15'h0, seqArmed});
        end
        $display("test software sequence done");
        finish_test();
    end
endmodule
bind pid_device_identity_register pid_chk #(.VERSION(VERSION), .GENERATION(GENERATION),
    .VENDOR(VENDOR)) pid_chk_inst (.clock(clock), .rst_n(rst_n), .pins(pins),
    .lineOut(lineOut), .lineOe(lineOe), .seqArmed(seqArmed));
`default_nettype wire
